// [hw/ppfm_pkg.sv]
// Constants and types for the port pin function multiplexer.
// Assumes a single 50 MHz bus clock and an AHB-Lite register port.
package ppfm_pkg;

// ==========================================================
// Sizes
localparam int NPIN = 35;
localparam int NREG = 9;
localparam int NFN = 4;
localparam int PINS_PER_REG = 4;
localparam int SEL_W = 2;

// ==========================================================
// Register indices; the byte address is four times the index.
localparam logic [29:0] REG_BASE_IDX = 30'h000052a0;
localparam logic [15:0] IDX_PORT0_LOW_PIN_FUNCTION = 16'h52a0;
localparam logic [15:0] IDX_PORT0_HIGH_PIN_FUNCTION = 16'h52a1;
localparam logic [15:0] IDX_PORT1_LOW_PIN_FUNCTION = 16'h52a2;
localparam logic [15:0] IDX_PORT1_HIGH_PIN_FUNCTION = 16'h52a3;
localparam logic [15:0] IDX_PORT2_LOW_PIN_FUNCTION = 16'h52a4;
localparam logic [15:0] IDX_PORT2_HIGH_PIN_FUNCTION = 16'h52a5;
localparam logic [15:0] IDX_PORT3_LOW_PIN_FUNCTION = 16'h52a6;
localparam logic [15:0] IDX_PORT3_HIGH_PIN_FUNCTION = 16'h52a7;
localparam logic [15:0] IDX_PORT4_PIN_FUNCTION = 16'h52a8;
localparam logic [3:0] SLOT_PORT4 = 4'h8;
localparam logic [7:0] SEL_RESET = 8'h00;
localparam logic [7:0] MASK_FULL = 8'hff;
localparam logic [7:0] MASK_PORT4 = 8'h3f;

// ==========================================================
// Selector codes and per-pin function tables.
localparam logic [1:0] CODE0 = 2'h0;
localparam logic [1:0] CODE1 = 2'h1;
localparam logic [1:0] CODE2 = 2'h2;
localparam logic [1:0] CODE3 = 2'h3;
// Bit pin*4+code is set where that code is a peripheral signal.
localparam logic [139:0] FN_ALT =
    140'h1112ee666666222266666eee66222222266;
// Bit pin*4+code is set where that code is plain port I/O.
localparam logic [139:0] FN_GPIO =
    140'h022_11111111_11111111_11111111_11111111;
// Pins whose plain mode also feeds external clock inputs 0 to 3.
localparam int EXT_CLK_PIN [4] = '{3, 0, 1, 19};

// ==========================================================
// Bus
localparam logic [31:0] RDATA_ZERO = 32'h00000000;
localparam logic [23:0] RDATA_PAD = 24'h000000;

typedef struct packed {
    logic [8:0][7:0] sel;
    logic wr_pend;
    logic [3:0] wr_idx;
    logic [31:0] rdata;
    logic ready;
    logic resp;
    logic [34:0] sync1;
    logic [34:0] sync2;
    logic [34:0] pout;
    logic [34:0] poe;
    logic [34:0] gin;
    logic [139:0] ain;
    logic [3:0] eclk;
} ppfm_state_s;

function automatic int fn_bit(input int pin, input int code);
    return pin * NFN + code;
endfunction

endpackage

// [hw/ppfm_port_pin_function_mux.sv]
// Pin function multiplexer for 35 port pins behind an AHB-Lite slave.
// Assumes pin levels are asynchronous and peripherals run on hclk.
//
// Overview of operation
// - Nine registers, four 2-bit selectors each (three in port4), reset zero.
// - Port0 pin3: plain with clock in, or trigger.
// - Port0 pin2: plain or timer 6.
// - Port0 pins 1,0: remote or serial clock.
// - Port0 pins 7..4: SPI channel 0 signals.
// - Port1 pin3: timer 3, analog 7, SPI2 out.
// - Port1 pins 2..0: serial 0 and SPI1.
// - Port1 pins 7..4: timers, analog, clock A, SPI2.
// - Port2 pins 3..0: sensor, analog, SPI selects.
// - Port2 pins 7..4: R/F converter, serial transmit 1.
// - Port3 pins 3..0: I2C, sensors, reference, serial.
// - Port3 pins 7,6: timers, oscillator input, buzzer.
// - Port3 pins 5,4: clock B, auxiliary, SDA.
// - Port4: debugger owns pins after reset.
//
// The AHB-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ns

module ppfm_port_pin_function_mux (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [34:0] pin_in,
    output logic [34:0] pin_out,
    output logic [34:0] pin_oe,
    input wire logic [34:0] gpio_out,
    input wire logic [34:0] gpio_oe,
    output logic [34:0] gpio_in,
    input wire logic [139:0] alt_out,
    input wire logic [139:0] alt_oe,
    output logic [139:0] alt_in,
    output logic [3:0] external_clock_input
);

ppfm_pkg::ppfm_state_s st;
ppfm_pkg::ppfm_state_s next_st;

// ==========================================================
// Decoding helpers
function automatic logic [1:0] pin_code(
    input logic [8:0][7:0] sel,
    input int pin
);
    logic [7:0] r;
    r = sel[pin / ppfm_pkg::PINS_PER_REG];
    return r[(pin % ppfm_pkg::PINS_PER_REG) * ppfm_pkg::SEL_W +: 2];
endfunction

function automatic logic [7:0] wmask(input logic [3:0] idx);
    return (idx == ppfm_pkg::SLOT_PORT4) ? ppfm_pkg::MASK_PORT4
                                         : ppfm_pkg::MASK_FULL;
endfunction

// ==========================================================
// Next state
always_comb begin
    logic [29:0] word_off;
    logic hit;
    logic [1:0] code;
    int k;
    logic is_gpio;
    logic is_alt;
    word_off = '0;
    hit = 1'b0;
    code = ppfm_pkg::CODE0;
    k = 0;
    is_gpio = 1'b0;
    is_alt = 1'b0;
    next_st = st;
    next_st.ready = 1'b1;
    next_st.resp = 1'b0;

    // Data phase of a write; reserved port4 bits stay zero.
    if (st.wr_pend) begin
        next_st.sel[st.wr_idx] = hwdata[7:0] & wmask(st.wr_idx);
    end

    // Address phase; zero wait states.
    next_st.wr_pend = 1'b0;
    word_off = haddr[31:2] - ppfm_pkg::REG_BASE_IDX;
    hit = (word_off < 30'(ppfm_pkg::NREG)) && (haddr[1:0] == 2'h0);
    if (hsel && htrans[1] && hready) begin
        if (hwrite) begin
            next_st.wr_pend = hit;
            next_st.wr_idx = word_off[3:0];
        end else if (hit) begin
            // Read from the updated copy so a read right after a
            // write to the same register sees the new value.
            next_st.rdata = {ppfm_pkg::RDATA_PAD,
                             next_st.sel[word_off[3:0]]};
        end else begin
            next_st.rdata = ppfm_pkg::RDATA_ZERO;
        end
    end

    // Pin levels pass two flops before any routing reads them.
    next_st.sync1 = pin_in;
    next_st.sync2 = st.sync1;

    // Routing uses the registered selectors, so a new code takes
    // effect one cycle after its write data phase.
    for (int p = 0; p < ppfm_pkg::NPIN; p++) begin
        code = pin_code(st.sel, p);
        k = ppfm_pkg::fn_bit(p, int'(code));
        is_gpio = ppfm_pkg::FN_GPIO[k];
        is_alt = ppfm_pkg::FN_ALT[k];
        if (is_gpio) begin
            next_st.pout[p] = gpio_out[p];
            next_st.poe[p] = gpio_oe[p];
        end else if (is_alt) begin
            next_st.pout[p] = alt_out[k];
            next_st.poe[p] = alt_oe[k];
        end else begin
            // Reserved code: the pin floats and feeds nothing.
            next_st.pout[p] = 1'b0;
            next_st.poe[p] = 1'b0;
        end
        next_st.gin[p] = is_gpio & st.sync2[p];
        for (int f = 0; f < ppfm_pkg::NFN; f++) begin
            next_st.ain[ppfm_pkg::fn_bit(p, f)] =
                ppfm_pkg::FN_ALT[ppfm_pkg::fn_bit(p, f)] &&
                (code == 2'(f)) && st.sync2[p];
        end
    end

    // External clock inputs follow their pin only in plain mode.
    for (int e = 0; e < 4; e++) begin
        next_st.eclk[e] =
            (pin_code(st.sel, ppfm_pkg::EXT_CLK_PIN[e]) ==
             ppfm_pkg::CODE0) &&
            st.sync2[ppfm_pkg::EXT_CLK_PIN[e]];
    end
end

// ==========================================================
// State register
always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        st.sel <= {ppfm_pkg::NREG{ppfm_pkg::SEL_RESET}};
        st.wr_pend <= 1'b0;
        st.wr_idx <= 4'h0;
        st.rdata <= 32'h00000000;
        st.ready <= 1'b1;
        st.resp <= 1'b0;
        st.sync1 <= '0;
        st.sync2 <= '0;
        st.pout <= '0;
        st.poe <= '0;
        st.gin <= '0;
        st.ain <= '0;
        st.eclk <= 4'h0;
    end else begin
        st <= next_st;
    end
end

// ==========================================================
// Outputs
assign hreadyout = st.ready;
assign hresp = st.resp;
assign hrdata = st.rdata;
assign pin_out = st.pout;
assign pin_oe = st.poe;
assign gpio_in = st.gin;
assign alt_in = st.ain;
assign external_clock_input = st.eclk;

// ==========================================================
// Checks
default clocking cb @(posedge hclk);
endclocking
default disable iff (!hresetn);

chk_write_store: assert property (
    st.wr_pend |=> st.sel[$past(st.wr_idx)] ==
        ($past(hwdata[7:0]) & wmask($past(st.wr_idx))))
    else $error("selector write not stored");

chk_read_back: assert property (
    (hsel && htrans[1] && hready && !hwrite && !st.wr_pend &&
     haddr[31:2] == ppfm_pkg::REG_BASE_IDX && haddr[1:0] == 2'h0)
    |=> hrdata == {ppfm_pkg::RDATA_PAD, $past(st.sel[0])})
    else $error("read data wrong");

chk_bus_okay: assert property (
    hreadyout && !hresp)
    else $error("bus not ready or error");

chk_adc_trigger: assert property (
    pin_code(st.sel, 3) == ppfm_pkg::CODE1
    |=> pin_out[3] == $past(alt_out[ppfm_pkg::fn_bit(3, 1)]))
    else $error("trigger pin not routed");

chk_ext_clock: assert property (
    pin_code(st.sel, 3) == ppfm_pkg::CODE1
    |=> !external_clock_input[0])
    else $error("clock input live in trigger mode");

chk_timer6_pin: assert property (
    pin_code(st.sel, 2) == ppfm_pkg::CODE1
    |=> pin_oe[2] == $past(alt_oe[ppfm_pkg::fn_bit(2, 1)]))
    else $error("timer 6 enable not routed");

chk_serial_clk0: assert property (
    pin_code(st.sel, 0) == ppfm_pkg::CODE2
    |=> pin_out[0] == $past(alt_out[ppfm_pkg::fn_bit(0, 2)]))
    else $error("serial clock 0 not routed");

chk_reserved_float: assert property (
    pin_code(st.sel, 7) == ppfm_pkg::CODE2
    |=> !pin_oe[7] && !alt_in[ppfm_pkg::fn_bit(7, 2)])
    else $error("reserved code drives pin");

chk_spi2_out: assert property (
    pin_code(st.sel, 11) == ppfm_pkg::CODE3
    |=> pin_out[11] == $past(alt_out[ppfm_pkg::fn_bit(11, 3)]))
    else $error("spi2 out not routed");

chk_serial_rx0: assert property (
    pin_code(st.sel, 10) == ppfm_pkg::CODE1 && st.sync2[10]
    |=> alt_in[ppfm_pkg::fn_bit(10, 1)] && !gpio_in[10])
    else $error("serial receive 0 not routed");

chk_clock_out_a: assert property (
    pin_code(st.sel, 13) == ppfm_pkg::CODE3
    |=> pin_oe[13] == $past(alt_oe[ppfm_pkg::fn_bit(13, 3)]))
    else $error("clock output a not routed");

chk_spi2_select: assert property (
    pin_code(st.sel, 18) == ppfm_pkg::CODE2
    |=> pin_out[18] == $past(alt_out[ppfm_pkg::fn_bit(18, 2)]))
    else $error("spi2 select not routed");

chk_serial_tx1: assert property (
    pin_code(st.sel, 23) == ppfm_pkg::CODE2
    |=> pin_out[23] == $past(alt_out[ppfm_pkg::fn_bit(23, 2)]))
    else $error("serial transmit 1 not routed");

chk_i2c_scl0: assert property (
    pin_code(st.sel, 25) == ppfm_pkg::CODE2
    |=> pin_oe[25] == $past(alt_oe[ppfm_pkg::fn_bit(25, 2)]))
    else $error("scl 0 not routed");

chk_buzzer_pin: assert property (
    pin_code(st.sel, 30) == ppfm_pkg::CODE3
    |=> pin_out[30] == $past(alt_out[ppfm_pkg::fn_bit(30, 3)]))
    else $error("buzzer not routed");

chk_aux_output: assert property (
    pin_code(st.sel, 29) == ppfm_pkg::CODE2
    |=> pin_out[29] == $past(alt_out[ppfm_pkg::fn_bit(29, 2)]))
    else $error("auxiliary output not routed");

chk_debug_owner: assert property (
    pin_code(st.sel, 34) == ppfm_pkg::CODE0
    |=> pin_oe[34] == $past(alt_oe[ppfm_pkg::fn_bit(34, 0)]))
    else $error("debug clock not routed");

chk_debug_release: assert property (
    pin_code(st.sel, 32) == ppfm_pkg::CODE1
    |=> pin_out[32] == $past(gpio_out[32]))
    else $error("released debug pin not plain");

chk_port4_reserved: assert property (
    st.sel[ppfm_pkg::SLOT_PORT4][7:6] == 2'h0)
    else $error("port4 reserved bits set");

chk_plain_input: assert property (
    pin_code(st.sel, 5) == ppfm_pkg::CODE0
    |=> gpio_in[5] == $past(pin_in[5], 3))
    else $error("plain input latency wrong");

// ==========================================================
// Routing checks for further pins. Each one watches a code that
// the checks above leave untouched; pins 6, 9, 14-17, 20-22, 26 and 27 have no check.
chk_remote_rx: assert property (
    pin_code(st.sel, 1) == ppfm_pkg::CODE1 && st.sync2[1]
    |=> alt_in[ppfm_pkg::fn_bit(1, 1)] && !external_clock_input[2])
    else $error("remote receive not routed");

chk_spi0_select: assert property (
    pin_code(st.sel, 7) == ppfm_pkg::CODE1
    |=> pin_oe[7] == $past(alt_oe[ppfm_pkg::fn_bit(7, 1)]))
    else $error("spi0 select not routed");

chk_spi0_clock: assert property (
    pin_code(st.sel, 4) == ppfm_pkg::CODE1
    |=> pin_out[4] == $past(alt_out[ppfm_pkg::fn_bit(4, 1)]))
    else $error("spi0 clock not routed");

chk_analog_in7: assert property (
    pin_code(st.sel, 11) == ppfm_pkg::CODE2
    |=> pin_oe[11] == $past(alt_oe[ppfm_pkg::fn_bit(11, 2)]))
    else $error("analog input 7 not routed");

chk_spi1_clock: assert property (
    pin_code(st.sel, 8) == ppfm_pkg::CODE1
    |=> pin_out[8] == $past(alt_out[ppfm_pkg::fn_bit(8, 1)]))
    else $error("spi1 clock not routed");

chk_spi2_data_in: assert property (
    pin_code(st.sel, 12) == ppfm_pkg::CODE3 && st.sync2[12]
    |=> alt_in[ppfm_pkg::fn_bit(12, 3)] && !gpio_in[12])
    else $error("spi2 data in not routed");

chk_sensor_b1: assert property (
    pin_code(st.sel, 19) == ppfm_pkg::CODE1
    |=> pin_out[19] == $past(alt_out[ppfm_pkg::fn_bit(19, 1)]) &&
        !external_clock_input[3])
    else $error("sensor b1 not routed");

chk_rf_input0: assert property (
    pin_code(st.sel, 23) == ppfm_pkg::CODE1
    |=> pin_oe[23] == $past(alt_oe[ppfm_pkg::fn_bit(23, 1)]))
    else $error("rf input 0 not routed");

chk_serial_rx1: assert property (
    pin_code(st.sel, 24) == ppfm_pkg::CODE2 && st.sync2[24]
    |=> alt_in[ppfm_pkg::fn_bit(24, 2)] && !gpio_in[24])
    else $error("serial receive 1 not routed");

chk_timer0_pin: assert property (
    pin_code(st.sel, 31) == ppfm_pkg::CODE1
    |=> pin_out[31] == $past(alt_out[ppfm_pkg::fn_bit(31, 1)]))
    else $error("timer 0 not routed");

chk_osc_input: assert property (
    pin_code(st.sel, 30) == ppfm_pkg::CODE2 && st.sync2[30]
    |=> alt_in[ppfm_pkg::fn_bit(30, 2)])
    else $error("oscillator input not routed");

chk_sda1_pin: assert property (
    pin_code(st.sel, 28) == ppfm_pkg::CODE1
    |=> pin_oe[28] == $past(alt_oe[ppfm_pkg::fn_bit(28, 1)]))
    else $error("sda 1 not routed");

chk_debug_reserved: assert property (
    pin_code(st.sel, 34) == ppfm_pkg::CODE1
    |=> !pin_oe[34] && !gpio_in[34])
    else $error("reserved debug code drives pin");

chk_debug_status: assert property (
    pin_code(st.sel, 33) == ppfm_pkg::CODE0
    |=> pin_out[33] == $past(alt_out[ppfm_pkg::fn_bit(33, 0)]))
    else $error("debug status not routed");

chk_plain_output: assert property (
    pin_code(st.sel, 2) == ppfm_pkg::CODE0
    |=> pin_out[2] == $past(gpio_out[2]) && pin_oe[2] == $past(gpio_oe[2]))
    else $error("plain output not routed");

chk_clock_in_plain: assert property (
    pin_code(st.sel, 3) == ppfm_pkg::CODE0
    |=> external_clock_input[0] == $past(st.sync2[3]))
    else $error("clock input not fed in plain mode");

cov_write_port0: cover property (
    st.wr_pend && st.wr_idx == 4'h0);
cov_spi_mode: cover property (
    pin_code(st.sel, 4) == ppfm_pkg::CODE1 && pin_oe[4]);
cov_buzzer_mode: cover property (
    pin_code(st.sel, 30) == ppfm_pkg::CODE3);
cov_debug_freed: cover property (
    pin_code(st.sel, 33) == ppfm_pkg::CODE1 && gpio_in[33]);
cov_reserved_code: cover property (
    pin_code(st.sel, 7) == ppfm_pkg::CODE3 && !pin_oe[7]);

endmodule

// [sim/ppfm_peripheral_model.sv]
// Stand-in for the peripherals and the port logic behind the pin mux.
// Assumes the bench steps the pattern selector just after a clock edge.
`timescale 1ns/1ns

module ppfm_peripheral_model (
    input wire logic hclk,
    input wire logic [1:0] step,
    output logic [139:0] alt_out = '0,
    output logic [139:0] alt_oe = '0,
    output logic [34:0] gpio_out = '0,
    output logic [34:0] gpio_oe = '0
);
    // ==========================================================
    // Drive
    // Each step lights a different code slot, so a signal routed from the
    // wrong slot of a pin shows as a wrong level within the four steps.
    always @(posedge hclk) begin
        alt_out <= {35{4'h1 << step}};
        alt_oe <= {35{4'h1 << step}} ^ {35{4'ha}};
        gpio_out <= 35'h2aaaa5555 ^ {35{step[0]}};
        gpio_oe <= 35'h53333cccc ^ {35{step[1]}};
    end
endmodule

// [sim/port_pin_function_mux_bench.sv]
// Self-checking bench for the pin function mux over AHB-Lite.
// Assumes the design answers with zero wait states and OKAY.
`timescale 1ns/1ns

module port_pin_function_mux_bench;
    // ==========================================================
    // Signals
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic [1:0] step = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [34:0] pin_in = 35'h0;
    logic hreadyout, hresp;
    logic [31:0] hrdata;
    logic [34:0] pin_out, pin_oe, gpio_out, gpio_oe, gpio_in;
    logic [139:0] alt_out, alt_oe, alt_in;
    logic [3:0] ext_clk;
    int fails = 0;
    int checks_done = 0;
    // Number of peripheral codes on each pin of ports 0 to 3.
    localparam int NALT [32] = '{2, 2, 1, 1, 1, 1, 1, 1, 1, 2, 2, 3, 3, 3,
        2, 2, 2, 2, 2, 1, 1, 1, 1, 2, 2, 2, 2, 2, 2, 3, 3, 1};

    ppfm_port_pin_function_mux DUT (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .gpio_out(gpio_out), .gpio_oe(gpio_oe), .gpio_in(gpio_in),
        .alt_out(alt_out), .alt_oe(alt_oe), .alt_in(alt_in),
        .external_clock_input(ext_clk));

    ppfm_peripheral_model far_side (.hclk(hclk), .step(step),
        .alt_out(alt_out), .alt_oe(alt_oe), .gpio_out(gpio_out),
        .gpio_oe(gpio_oe));

    initial begin
        forever #10 hclk = ~hclk;
    end

    // ==========================================================
    // Tasks
    task automatic give_verdict;
        $display("TB summary: %0d mismatches in %0d checks", fails,
            checks_done);
        if (fails == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic check(input logic [139:0] got, input logic [139:0] exp,
        input string what);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask

    // One single transfer; index 9 lies past the last register.
    // Ready, data and response are read just before the edge at which
    // they are sampled, so the design's own update cannot race them.
    task automatic bus(input int k, input logic wr, input logic [7:0] wd,
        output logic [31:0] rd);
        logic rdy;
        logic rsp;
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {ppfm_pkg::REG_BASE_IDX + 30'(k), 2'b00};
        htrans <= 2'h2;
        hwrite <= wr;
        do begin
            @(negedge hclk);
            rdy = hreadyout;
            @(posedge hclk);
        end while (rdy !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        do begin
            @(negedge hclk);
            rdy = hreadyout;
            rd = hrdata;
            rsp = hresp;
            @(posedge hclk);
        end while (rdy !== 1'b1);
        check(rsp, 1'b0, "response");
    endtask

    // Code 2 offers the channel 0 I2C lines on two pins each; the
    // second pin of each pair stays plain so every line has one pin.
    function automatic int code_of(input int p, input int c);
        return (c == 2 && (p == 27 || p == 28)) ? 0 : c;
    endfunction

    // 0 plain port, 1 peripheral, 2 reserved.
    function automatic int kind(input int p, input int c);
        if (p >= 32) return (c == 0) ? 1 : ((c == 1 && p < 34) ? 0 : 2);
        if (c == 0) return 0;
        return (c <= NALT[p]) ? 1 : 2;
    endfunction

    task automatic check_pins(input int c);
        int b;
        int t;
        int cp;
        logic [3:0] ain;
        check(ext_clk, (c == 0) ? {pin_in[19], pin_in[1], pin_in[0],
            pin_in[3]} : 4'h0, "clock input");
        for (int p = 0; p < 35; p++) begin
            cp = code_of(p, c);
            b = p * 4 + cp;
            t = kind(p, cp);
            ain = (t == 1) ? (4'(pin_in[p]) << cp) : 4'h0;
            check(alt_in[p*4+:4], ain, "peripheral in");
            check(gpio_in[p], (t == 0) ? pin_in[p] : 1'b0, "plain in");
            if (t == 0) begin
                check({pin_out[p], pin_oe[p]}, {gpio_out[p], gpio_oe[p]},
                    "plain out");
            end else if (t == 1) begin
                check({pin_out[p], pin_oe[p]}, {alt_out[b], alt_oe[b]},
                    "peripheral out");
            end else begin
                check(pin_oe[p], 1'b0, "reserved code");
            end
        end
    endtask

    // ==========================================================
    // Tests
    initial begin
        logic [31:0] rd;
        logic [7:0] wv;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        for (int k = 0; k < 10; k++) begin
            bus(k, 1'b0, 8'h0, rd);
            check(rd, 32'h0, "reset value");
        end
        for (int k = 0; k < 10; k++) begin
            bus(k, 1'b1, 8'hc0 | 8'(k * 5), rd);
        end
        for (int k = 0; k < 10; k++) begin
            wv = 8'hc0 | 8'(k * 5);
            bus(k, 1'b0, 8'h0, rd);
            wv = (k == 9) ? 8'h0 : ((k == 8) ? (wv & 8'h3f) : wv);
            check(rd, {24'h0, wv}, "read back");
        end
        // Every selector but those of pins 27 and 28 under code 2 gets the same code, reserved ones included.
        for (int c = 0; c < 4; c++) begin
            for (int k = 0; k < 9; k++) begin
                for (int q = 0; q < 4; q++) begin
                    wv[q*2+:2] = 2'(code_of(k * 4 + q, c));
                end
                bus(k, 1'b1, wv, rd);
            end
            for (int s = 0; s < 4; s++) begin
                @(posedge hclk);
                step <= 2'(s);
                pin_in <= 35'h35a5ac3c3 ^ {35{s[0]}};
                repeat (4) @(posedge hclk);
                #1;
                check_pins(c);
            end
        end
        give_verdict();
    end

    initial begin
        #200000;
        fails++;
        give_verdict();
    end
endmodule
